/* tsi_cm_consts.svh */
// offsets, field positions, reset values and timing counts of the connection memory control
// assumes a 10 MHz aclk and 16-bit device word addresses mapped onto aligned 32-bit words
`ifndef TSI_CM_CONSTS_SVH
`define TSI_CM_CONSTS_SVH

// device word address = axi byte address / 4
`define SEL_CTRL 2'b01
`define SEL_CMEM 2'b10
`define CTRL_ADDR 16'h4000
`define CTRL_RESET 16'h0000

`define CTRL_ALLOW_BIT 9
`define CTRL_PAT_HI 8
`define CTRL_PAT_LO 7
`define CTRL_TRIG_BIT 6
`define CTRL_RATE_HI 3
`define CTRL_RATE_LO 0
`define FILL_LOW_BITS 14'h0000

`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`define AXI_DECERR 2'b11

`define CLK_PERIOD_NS 100
`define FRAME_NS 125000
`define FILL_FRAMES 2
// longest time rounds down
`define FILL_LIMIT_CYC ((`FILL_FRAMES * `FRAME_NS) / `CLK_PERIOD_NS)

`endif

/* tsi_cm_ctrl.sv */
// connection memory, block fill engine, rate decode and axi4-lite register slave
// assumes one clock, synchronous reset, and a switching core that polls sw_dest
//
// Overview of operation
// - entry top bits select the switching mode
// - address 15:14 = 10 selects connection memory
// - entry bits 13:8 name source stream
// - entry bits 7:0 name source channel
// - control register holds allow, pattern, trigger bits
// - trigger rise fills whole memory within two frames
// - fill writes pattern on top, zeros below
// - pattern field clears itself after fill
// - allow bit low blocks hardware fill
// - regular and mux/demux rate modes supported
// - code 0100: rx 2M 0-15, tx 8M 0-3
// - code 0101: rx 8M 0-3, tx 2M 0-15
// - code 1001: rx 2M 0-15, tx 16M 0-3
// - code 1011: rx 8M 0-15, tx 16M 0-7
`timescale 1ns/10ps
`default_nettype none
`include "tsi_cm_consts.svh"
module tsi_cm_ctrl #(
  parameter int STREAM_W = 6,
  parameter int SLOT_W = 8,
  parameter int BANK_W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [STREAM_W+SLOT_W-1:0] sw_dest,
  output tsi_cm_pkg::cm_entry_s sw_entry,
  output tsi_cm_pkg::rate_cfg_s rate_cfg,
  output logic fill_busy
);
  import tsi_cm_pkg::*;
  localparam int AW = STREAM_W + SLOT_W;
  localparam int BANKS = 1 << BANK_W;
  localparam int ROW_W = AW - BANK_W;
  localparam int ROWS = 1 << ROW_W;
  localparam int FILL_LIM = `FILL_LIMIT_CYC;

  // ==========================================================
  // write channel
  logic aw_held;
  logic w_held;
  logic [15:0] aw_addr_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic do_write;
  logic wr_ctrl;
  logic wr_cmem;
  logic trig_rise;
  logic fill_start;
  logic fill_done;
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  fill_state_e fill_state;
  logic [ROW_W-1:0] fill_row;
  logic [1:0] fill_pat;
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_ctrl = do_write && aw_addr_q == `CTRL_ADDR;
  // processor writes lose against a running fill; the fill owns every row
  assign wr_cmem = do_write && aw_addr_q[15:14] == `SEL_CMEM && fill_state == FILL_IDLE;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      awready <= 1'b1;
      aw_addr_q <= 16'h0000;
    end
    else if (awvalid && awready)
    begin
      aw_held <= 1'b1;
      awready <= 1'b0;
      aw_addr_q <= awaddr[17:2];
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
      awready <= 1'b1;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      wready <= 1'b1;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'b00;
    end
    else if (wvalid && wready)
    begin
      w_held <= 1'b1;
      wready <= 1'b0;
      wdata_q <= wdata[15:0];
      wstrb_q <= wstrb[1:0];
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
      wready <= 1'b1;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= `AXI_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      if (aw_addr_q == `CTRL_ADDR || wr_cmem)
        bresp <= `AXI_OKAY;
      else if (aw_addr_q[15:14] == `SEL_CMEM)
        bresp <= `AXI_SLVERR;
      else
        bresp <= `AXI_DECERR;
    end
    else if (bvalid && bready)
      bvalid <= 1'b0;
  end

  // ==========================================================
  // control register
  always_comb
  begin
    next_ctrl = ctrl;
    if (wstrb_q[0])
      next_ctrl[7:0] = wdata_q[7:0];
    if (wstrb_q[1])
      next_ctrl[15:8] = wdata_q[15:8];
  end
  // only the edge of the trigger starts a fill; a held one does nothing
  assign trig_rise = wr_ctrl && !ctrl[`CTRL_TRIG_BIT] && next_ctrl[`CTRL_TRIG_BIT];
  assign fill_start = trig_rise && next_ctrl[`CTRL_ALLOW_BIT] && fill_state == FILL_IDLE;
  assign fill_done = fill_state == FILL_RUN && fill_row == ROW_W'(ROWS - 1);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= `CTRL_RESET;
    else
    begin
      if (wr_ctrl)
        ctrl <= next_ctrl;
      // completion wins over a same-cycle pattern write
      if (fill_done)
        ctrl[`CTRL_PAT_HI:`CTRL_PAT_LO] <= 2'b00;
    end
  end

  // ==========================================================
  // block fill engine: all banks take one row per cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fill_state <= FILL_IDLE;
      fill_busy <= 1'b0;
      fill_row <= '0;
      fill_pat <= 2'b00;
    end
    else
    begin
      unique case (fill_state)
        FILL_IDLE:
          if (fill_start)
          begin
            fill_state <= FILL_RUN;
            fill_busy <= 1'b1;
            fill_row <= '0;
            fill_pat <= next_ctrl[`CTRL_PAT_HI:`CTRL_PAT_LO];
          end
        FILL_RUN:
          if (fill_done)
          begin
            fill_state <= FILL_IDLE;
            fill_busy <= 1'b0;
          end
          else
            fill_row <= fill_row + 1'b1;
      endcase
    end
  end

  // ==========================================================
  // banked memory; banking keeps the fill inside two frames
  logic [ROW_W-1:0] cpu_row;
  logic [ROW_W-1:0] wr_row;
  logic [BANK_W-1:0] wr_bank;
  logic [15:0] cpu_q [BANKS];
  logic [15:0] sw_q [BANKS];
  logic [BANK_W-1:0] sw_bank_q;
  logic [15:0] sw_word;
  assign wr_row = aw_addr_q[AW-1:BANK_W];
  assign wr_bank = aw_addr_q[BANK_W-1:0];
  for (genvar b = 0; b < BANKS; b++)
  begin : gen_bank
    logic [15:0] mem [ROWS];
    always_ff @(posedge aclk)
    begin
      if (fill_state == FILL_RUN)
        mem[fill_row] <= {fill_pat, `FILL_LOW_BITS};
      else if (wr_cmem && wr_bank == BANK_W'(b))
      begin
        if (wstrb_q[0])
          mem[wr_row][7:0] <= wdata_q[7:0];
        if (wstrb_q[1])
          mem[wr_row][15:8] <= wdata_q[15:8];
      end
      cpu_q[b] <= mem[cpu_row];
      sw_q[b] <= mem[sw_dest[AW-1:BANK_W]];
    end
  end

  // ==========================================================
  // switching-side read port, two cycles from sw_dest
  assign sw_word = sw_q[sw_bank_q];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw_bank_q <= '0;
      sw_entry <= '0;
    end
    else
    begin
      sw_bank_q <= sw_dest[BANK_W-1:0];
      sw_entry <= cm_entry_s'(sw_word);
    end
  end

  // ==========================================================
  // read channel
  logic [15:0] ar_addr_q;
  logic [1:0] rd_phase;
  assign cpu_row = ar_addr_q[AW-1:BANK_W];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rd_phase <= 2'd0;
      ar_addr_q <= 16'h0000;
      rdata <= 32'h0000_0000;
      rresp <= `AXI_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      ar_addr_q <= araddr[17:2];
      rd_phase <= 2'd1;
    end
    else if (rd_phase == 2'd1)
      rd_phase <= 2'd2;
    else if (rd_phase == 2'd2)
    begin
      rd_phase <= 2'd3;
      rvalid <= 1'b1;
      rresp <= `AXI_OKAY;
      rdata <= 32'h0000_0000;
      if (ar_addr_q == `CTRL_ADDR)
        rdata <= {16'h0000, ctrl};
      else if (ar_addr_q[15:14] == `SEL_CMEM)
        rdata <= {16'h0000, cpu_q[ar_addr_q[BANK_W-1:0]]};
      else
        rresp <= `AXI_DECERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
      rd_phase <= 2'd0;
    end
  end

  // ==========================================================
  // rate combination decode
  logic [3:0] rate_sel;
  assign rate_sel = ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rate_cfg <= '{1'b0, RATE_2M, 5'd15, RATE_2M, 5'd15};
    else
    begin
      case (rate_sel)
        4'h4: rate_cfg <= '{1'b1, RATE_2M, 5'd15, RATE_8M, 5'd3};
        4'h5: rate_cfg <= '{1'b1, RATE_8M, 5'd3, RATE_2M, 5'd15};
        4'h6: rate_cfg <= '{1'b1, RATE_4M, 5'd15, RATE_8M, 5'd7};
        4'h7: rate_cfg <= '{1'b1, RATE_8M, 5'd7, RATE_4M, 5'd15};
        4'h8: rate_cfg <= '{1'b1, RATE_16M, 5'd1, RATE_2M, 5'd15};
        4'h9: rate_cfg <= '{1'b1, RATE_2M, 5'd15, RATE_16M, 5'd3};
        4'ha: rate_cfg <= '{1'b1, RATE_16M, 5'd7, RATE_8M, 5'd15};
        4'hb: rate_cfg <= '{1'b1, RATE_8M, 5'd15, RATE_16M, 5'd7};
        // regular mode: one rate both ways
        4'h0, 4'h1, 4'h2, 4'h3:
          rate_cfg <= '{1'b0, rate_e'(rate_sel[1:0]), 5'd15, rate_e'(rate_sel[1:0]), 5'd15};
        default: rate_cfg <= '{1'b0, RATE_2M, 5'd15, RATE_2M, 5'd15};
      endcase
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [11:0] busy_cyc;
  always_ff @(posedge aclk) busy_cyc <= (aresetn && fill_busy) ? busy_cyc + 12'h001 : 12'h000;
  AST_MODE_FIELD: assert property (##1 sw_entry[15:14] === $past(sw_word[15:14]))
    else $error("switch mode field not taken from entry bits 15:14");
  AST_CMEM_WRITE_OK: assert property (wr_cmem |=> bvalid && bresp == `AXI_OKAY)
    else $error("connection memory write not answered okay");
  AST_STREAM_FIELD: assert property (##1 sw_entry[13:8] === $past(sw_word[13:8]))
    else $error("source stream not taken from entry bits 13:8");
  AST_CHANNEL_FIELD: assert property (##1 sw_entry[7:0] === $past(sw_word[7:0]))
    else $error("source channel not taken from entry bits 7:0");
  AST_CTRL_ALLOW: assert property (wr_ctrl && wstrb_q[1] |=> ctrl[9] == $past(wdata_q[9]))
    else $error("allow bit not stored at bit 9");
  AST_FILL_BOUND: assert property ((fill_start |=> fill_busy) and
    busy_cyc < 12'(FILL_LIM))
    else $error("block fill exceeded two frames");
  AST_FILL_WORD: assert property ($fell(fill_busy) |-> gen_bank[0].mem[0] == {fill_pat, 14'h0})
    else $error("filled word differs from pattern with zero low bits");
  AST_PAT_CLEAR: assert property ($fell(fill_busy) |-> ctrl[8:7] == 2'b00)
    else $error("fill pattern not cleared at completion");
  AST_NO_FILL: assert property (trig_rise && !next_ctrl[9] && !fill_busy |=> !fill_busy)
    else $error("fill ran with allow bit low");
  AST_RATE_0100: assert property (rate_sel == 4'h4 |=> rate_cfg.tx_rate == RATE_8M
    && rate_cfg.tx_last_stream == 5'd3 && rate_cfg.rx_last_stream == 5'd15)
    else $error("code 0100 decoded wrongly");
  AST_RATE_1011: assert property (rate_sel == 4'hb |=> rate_cfg.mux_demux
    && rate_cfg.tx_rate == RATE_16M && rate_cfg.rx_rate == RATE_8M)
    else $error("code 1011 decoded wrongly");
  COV_FILL: cover property (fill_start ##1 fill_busy [*3]);
  COV_CMEM_READ: cover property (rvalid && ar_addr_q[15:14] == `SEL_CMEM);
  COV_BUSY_WRITE: cover property (do_write && aw_addr_q[15:14] == `SEL_CMEM && fill_busy);
  COV_MUX: cover property (rate_cfg.mux_demux);

endmodule

`default_nettype wire

/* tsi_cm_ctrl_tb.sv */
// self-checking bench: axi4-lite master, switch-port poller, queue-based checking
// assumes the design files and tsi_cm_consts.svh are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "tsi_cm_consts.svh"

module tsi_cm_ctrl_tb;
  import tsi_cm_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, fill_busy, sp_req, got_v;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [13:0] sw_dest, sp_dest;
  cm_entry_s sw_entry;
  rate_cfg_s rate_cfg;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] sq[$];
  logic [13:0] d[4];
  logic [15:0] v[4];
  int fail_count, comparisons, cyc, t0;

  tsi_cm_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sw_dest(sw_dest), .sw_entry(sw_entry), .rate_cfg(rate_cfg), .fill_busy(fill_busy));
  tsi_cm_sw_poller poller (.aclk(aclk), .aresetn(aresetn), .req(sp_req), .dest(sp_dest),
    .sw_dest(sw_dest), .got_v(got_v));

  // ==========================================
  // checking and report
  task automatic cmp_word(input string n, input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_rate(input rate_cfg_s e);
    comparisons++;
    if (rate_cfg !== e)
    begin
      fail_count++;
      $display("mismatch rate_cfg expected %h seen %h", e, rate_cfg);
    end
  endtask

  task automatic final_report;
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always #50 aclk = ~aclk;

  // 20000 cycles is several times the two fills plus register traffic
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      final_report();
    end
  end

  // results are matched to the oldest note of their kind
  always @(posedge aclk)
  begin
    if (rvalid === 1'b1 && rready)
      cmp_word("read", rq.size() ? rq.pop_front() : 'x, {rresp, rdata});
    if (bvalid === 1'b1 && bready)
      cmp_word("bresp", bq.size() ? bq.pop_front() : 'x, bresp);
    if (got_v)
      cmp_word("sw_entry", sq.size() ? sq.pop_front() : 'x, sw_entry);
  end

  // ==========================================
  // drivers
  function automatic logic [31:0] ma(input logic [13:0] x);
    ma = {14'h0, 2'b10, x, 2'b00};
  endfunction

  task automatic axw(input logic [31:0] a, input logic [15:0] x, input logic [1:0] er);
    bq.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0, x};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [31:0] a, input logic [15:0] x, input logic [1:0] er);
    rq.push_back({er, 16'h0, x});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic swchk(input logic [13:0] x, input logic [15:0] e);
    sq.push_back(e);
    @(posedge aclk);
    sp_dest <= x;
    sp_req <= 1'b1;
    @(posedge aclk);
    sp_req <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic wait_fill;
    int n;
    n = 0;
    while (fill_busy !== 1'b1 && n < 8)
    begin
      @(posedge aclk);
      n++;
    end
    t0 = cyc;
    while (fill_busy === 1'b1 && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    cmp_word("fill_time", 1, n < 8 + `FILL_LIMIT_CYC && cyc - t0 > 1);
  endtask

  function automatic rate_cfg_s rexp(input logic [3:0] c);
    case (c)
      4'h4: rexp = {1'b1, RATE_2M, 5'd15, RATE_8M, 5'd3};
      4'h5: rexp = {1'b1, RATE_8M, 5'd3, RATE_2M, 5'd15};
      4'h6: rexp = {1'b1, RATE_4M, 5'd15, RATE_8M, 5'd7};
      4'h7: rexp = {1'b1, RATE_8M, 5'd7, RATE_4M, 5'd15};
      4'h8: rexp = {1'b1, RATE_16M, 5'd1, RATE_2M, 5'd15};
      4'h9: rexp = {1'b1, RATE_2M, 5'd15, RATE_16M, 5'd3};
      4'ha: rexp = {1'b1, RATE_16M, 5'd7, RATE_8M, 5'd15};
      4'hb: rexp = {1'b1, RATE_8M, 5'd15, RATE_16M, 5'd7};
      4'hc, 4'hd, 4'he, 4'hf: rexp = {1'b0, RATE_2M, 5'd15, RATE_2M, 5'd15};
      default: rexp = {1'b0, rate_e'(c[1:0]), 5'd15, rate_e'(c[1:0]), 5'd15};
    endcase
  endfunction

  // ==========================================
  // main sequence
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sp_req} = 8'h00;
    {awaddr, wdata, araddr, sp_dest} = '0;
    wstrb = 4'hf;
    cyc = 0;
    void'($urandom(32'h108b));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axr(32'h10000, `CTRL_RESET, `AXI_OKAY);
    cmp_rate(rexp(4'h0));
    for (int i = 0; i < 4; i++)
    begin
      d[i] = {i[1:0], 12'($urandom)};
      v[i] = {i[1:0], 14'($urandom)};
      axw(ma(d[i]), v[i], `AXI_OKAY);
      axr(ma(d[i]), v[i], `AXI_OKAY);
      swchk(d[i], v[i]);
    end
    axw(32'h0, 16'h1234, `AXI_DECERR);
    axr(32'h30000, 16'h0, `AXI_DECERR);
    for (int c = 0; c < 16; c++)
    begin
      axw(32'h10000, 16'(c), `AXI_OKAY);
      repeat (2) @(posedge aclk);
      cmp_rate(rexp(4'(c)));
    end
    // high lane only: the rate code in the low byte must survive
    wstrb <= 4'h2;
    axw(32'h10000, 16'h02ff, `AXI_OKAY);
    wstrb <= 4'hf;
    axr(32'h10000, 16'h020f, `AXI_OKAY);
    // trigger rises with the allow bit low
    axw(32'h10000, 16'h0180, `AXI_OKAY);
    axw(32'h10000, 16'h01c0, `AXI_OKAY);
    repeat (4) @(posedge aclk);
    cmp_word("fill_busy", 0, fill_busy);
    axr(32'h10000, 16'h01c0, `AXI_OKAY);
    axr(ma(d[0]), v[0], `AXI_OKAY);
    axw(32'h10000, 16'h0300, `AXI_OKAY);
    axw(32'h10000, 16'h0340, `AXI_OKAY);
    @(posedge aclk);
    axw(ma(d[1]), 16'h1111, `AXI_SLVERR);
    wait_fill();
    axr(32'h10000, 16'h0240, `AXI_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      axr(ma(d[i]), {2'b10, `FILL_LOW_BITS}, `AXI_OKAY);
      swchk(14'($urandom), 16'h8000);
    end
    axw(ma(d[2]), v[2], `AXI_OKAY);
    swchk(d[2], v[2]);
    // trigger already high: no refill until it is lowered first
    axw(32'h10000, 16'h03c0, `AXI_OKAY);
    repeat (4) @(posedge aclk);
    cmp_word("fill_busy", 0, fill_busy);
    axw(32'h10000, 16'h0380, `AXI_OKAY);
    axw(32'h10000, 16'h03c0, `AXI_OKAY);
    wait_fill();
    axr(ma(d[2]), 16'hc000, `AXI_OKAY);
    axr(32'h10000, 16'h0240, `AXI_OKAY);
    repeat (4) @(posedge aclk);
    final_report();
  end
endmodule
`default_nettype wire

/* tsi_cm_pkg.sv */
// types shared by the connection memory control block
// assumes tsi_cm_consts.svh for all numeric constants
`default_nettype none
package tsi_cm_pkg;

  typedef enum logic [1:0] {
    MODE_VAR_DELAY = 2'b00,
    MODE_CONST_DELAY = 2'b01,
    MODE_PROCESSOR = 2'b10,
    MODE_OUT_HIGH = 2'b11
  } switch_mode_e;

  typedef enum logic [1:0] {
    RATE_2M = 2'b00,
    RATE_4M = 2'b01,
    RATE_8M = 2'b10,
    RATE_16M = 2'b11
  } rate_e;

  typedef enum logic {
    FILL_IDLE = 1'b0,
    FILL_RUN = 1'b1
  } fill_state_e;

  typedef struct packed {
    switch_mode_e switch_mode_sel;
    logic [5:0] source_stream_num;
    logic [7:0] source_channel_num;
  } cm_entry_s;

  typedef struct packed {
    logic mux_demux;
    rate_e rx_rate;
    logic [4:0] rx_last_stream;
    rate_e tx_rate;
    logic [4:0] tx_last_stream;
  } rate_cfg_s;

endpackage

`default_nettype wire

/* tsi_cm_sw_poller.sv */
// switching core model: polls one destination on request, idles on a moving address
// assumes sw_entry answers two edges after sw_dest is sampled
`timescale 1ns/10ps
`default_nettype none

module tsi_cm_sw_poller (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic [13:0] dest,
  output logic [13:0] sw_dest,
  output logic got_v
);
  logic [2:0] pipe;

  // ==========================================
  // destination drive
  // idle address keeps moving so a stale lookup cannot pass
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sw_dest <= 14'h0000;
    else if (req)
      sw_dest <= dest;
    else
      sw_dest <= sw_dest + 14'h0001;
  end

  // ==========================================
  // answer timing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pipe <= 3'h0;
    else
      pipe <= {pipe[1:0], req};
  end
  assign got_v = pipe[2];
endmodule
`default_nettype wire
